// File: rtl/icu_pkg.sv
// Constants, register map and carrier types for the priority interrupt controller
package icu_pkg;

  localparam int unsigned ICU_NSRC    = 11;
  localparam int unsigned ICU_NREG    = 6;
  localparam int unsigned ICU_NLEVEL  = 4;

  // Source index equals position in the polling order
  localparam logic [3:0] ICU_SRC_EXT0    = 4'h0;
  localparam logic [3:0] ICU_SRC_TIMER0  = 4'h1;
  localparam logic [3:0] ICU_SRC_EXT1    = 4'h2;
  localparam logic [3:0] ICU_SRC_TIMER1  = 4'h3;
  localparam logic [3:0] ICU_SRC_CAPTURE = 4'h4;
  localparam logic [3:0] ICU_SRC_SERIAL  = 4'h5;
  localparam logic [3:0] ICU_SRC_TIMER2  = 4'h6;
  localparam logic [3:0] ICU_SRC_CAN     = 4'h7;
  localparam logic [3:0] ICU_SRC_ADC     = 4'h8;
  localparam logic [3:0] ICU_SRC_CANOVF  = 4'h9;
  localparam logic [3:0] ICU_SRC_SPI     = 4'ha;

  // Vector address per source, indexed by polling position
  localparam logic [15:0] ICU_VECTOR [ICU_NSRC] = '{
    16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0033, 16'h0023,
    16'h002b, 16'h003b, 16'h0043, 16'h004b, 16'h0053};

  // Register indices; byte address is four times the index
  localparam logic [7:0] ICU_IDX_EN_MAIN   = 8'ha8;
  localparam logic [7:0] ICU_IDX_EN_SECOND = 8'he8;
  localparam logic [7:0] ICU_IDX_PL_MAIN   = 8'hb8;
  localparam logic [7:0] ICU_IDX_PH_MAIN   = 8'hb7;
  localparam logic [7:0] ICU_IDX_PL_SECOND = 8'hf8;
  localparam logic [7:0] ICU_IDX_PH_SECOND = 8'hf7;
  localparam logic [7:0] ICU_IDX_BITOP     = 8'h40;
  localparam logic [7:0] ICU_IDX_STATUS    = 8'h41;
  localparam logic [7:0] ICU_IDX_MASK      = 8'h42;
  localparam logic [7:0] ICU_IDX_STATE     = 8'h43;

  // Register file slots
  localparam logic [2:0] ICU_REG_EN_MAIN   = 3'h0;
  localparam logic [2:0] ICU_REG_EN_SECOND = 3'h1;
  localparam logic [2:0] ICU_REG_PL_MAIN   = 3'h2;
  localparam logic [2:0] ICU_REG_PH_MAIN   = 3'h3;
  localparam logic [2:0] ICU_REG_PL_SECOND = 3'h4;
  localparam logic [2:0] ICU_REG_PH_SECOND = 3'h5;
  localparam logic [2:0] ICU_REG_NONE      = 3'h7;

  localparam logic [7:0] ICU_WMASK [ICU_NREG] = '{8'hff, 8'h0f, 8'h7f, 8'h7f, 8'h0f, 8'h0f};
  localparam logic [7:0] ICU_RESET [ICU_NREG] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  localparam int unsigned ICU_GLOBAL_EN_BIT = 7;

  // Bit-operation word layout
  localparam int unsigned ICU_BITOP_BIT_LSB = 0;
  localparam int unsigned ICU_BITOP_SEL_LSB = 3;
  localparam int unsigned ICU_BITOP_VAL_BIT = 8;

  // Event status bits
  localparam int unsigned ICU_EV_TAKEN   = 0;
  localparam int unsigned ICU_EV_RETURN  = 1;
  localparam int unsigned ICU_EV_PREEMPT = 2;
  localparam int unsigned ICU_NEV        = 3;
  localparam logic [ICU_NEV-1:0] ICU_EV_RESET = 3'h0;

  localparam logic [15:0] ICU_VECTOR_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ICU_ST_IDLE  = 2'b00,
    ICU_ST_OFFER = 2'b01
  } icu_state_e;

  typedef struct packed {
    logic        valid;
    logic [1:0]  level;
    logic [15:0] vector;
  } icu_req_s;

  typedef struct packed {
    logic        valid;
    logic [1:0]  level;
    logic [3:0]  index;
  } icu_pick_s;

endpackage

// File: rtl/icu_sync.sv
// Two-stage synchroniser for asynchronous request pins
`timescale 1ns/1ns
`default_nettype none
module icu_sync
  import icu_pkg::*;
#(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule
`default_nettype wire

// File: rtl/icu_arbiter.sv
// Level-then-polling-order arbiter over all sources
`timescale 1ns/1ns
`default_nettype none
module icu_arbiter
  import icu_pkg::*;
(
  input  wire logic [ICU_NSRC-1:0] pending,
  input  wire logic [1:0]          level [ICU_NSRC],
  output icu_pick_s                pick
);

  logic [ICU_NLEVEL-1:0] any_at;
  logic [ICU_NSRC-1:0]   hit;
  logic [1:0]            best;

  always_comb begin
    any_at = '0;
    for (int i = 0; i < ICU_NSRC; i++) begin
      if (pending[i]) begin
        any_at[level[i]] = 1'b1;
      end
    end
  end

  // Highest level with a request wins
  always_comb begin
    best = 2'h0;
    for (int l = 0; l < ICU_NLEVEL; l++) begin
      if (any_at[l]) begin
        best = l[1:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < ICU_NSRC; g++) begin : g_hit
      assign hit[g] = pending[g] && (level[g] == best);
    end
  endgenerate

  // Earliest polling position among equal levels
  always_comb begin
    pick.valid = |pending;
    pick.level = best;
    pick.index = 4'h0;
    for (int i = ICU_NSRC - 1; i >= 0; i--) begin
      if (hit[i]) begin
        pick.index = i[3:0];
      end
    end
  end

endmodule
`default_nettype wire

// File: rtl/icu_controller.sv
// Priority interrupt controller: enables, priorities, arbitration, vectoring and register slave
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Every source has its own software enable bit.
// - Global enable at bit 7 blocks all requests while clear.
// - High and low bits form level 0 (lowest) to 3 (highest).
// - Higher level preempts a running handler; equal level does not.
// - A level 3 handler is never preempted.
// - Simultaneous requests: the higher level is served first.
// - Equal levels are resolved by a fixed polling order.
// - Order: ext0, timer0, ext1, timer1, capture, serial, timer2, CAN, ADC, overflow, SPI.
// - Each source has its fixed vector address, 0003h through 0053h.
// - CAN, capture and serial requests are the OR of their flags.
// - Main enable holds seven source enables in bits 6..0, resets zero.
// - Second enable holds SPI, overrun, ADC, CAN in bits 3..0, resets zero.
// - The overrun enable gates the CAN timer overflow request.
// - Main low-priority register holds seven low bits in bits 6..0.
// - Main high-priority register holds matching high bits, same positions.
// - Second low-priority register holds SPI, overrun, ADC, CAN low bits.
module icu_controller
  import icu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,

  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,

  input  wire logic        external_request_zero,
  input  wire logic        external_request_one,
  input  wire logic        timer0_overflow_flag,
  input  wire logic        timer1_overflow_flag,
  input  wire logic        timer2_overflow_flag,
  input  wire logic        capture_counter_flag,
  input  wire logic [4:0]  capture_module_flag,
  input  wire logic        uart_rx_flag,
  input  wire logic        uart_tx_flag,
  input  wire logic        can_tx_ok,
  input  wire logic        can_rx_ok,
  input  wire logic        can_error,
  input  wire logic        can_buffer_overrun,
  input  wire logic        converter_done_flag,
  input  wire logic        can_timer_overflow_flag,
  input  wire logic        spi_request_flag,

  output icu_req_s         core_req,
  input  wire logic        core_ack,
  input  wire logic        core_return,
  output logic             irq
);

  logic [7:0]          regs_reg [ICU_NREG];

  logic [1:0]          ext_sync;
  logic [ICU_NSRC-1:0] raw_req;
  logic [ICU_NSRC-1:0] src_enable;
  logic [ICU_NSRC-1:0] pending;
  logic [1:0]          level [ICU_NSRC];

  icu_pick_s           pick;
  logic                can_preempt;

  logic [ICU_NLEVEL-1:0] in_service_reg;
  logic [ICU_NLEVEL-1:0] in_service_next;
  logic                any_active;
  logic [1:0]          active_level;

  icu_state_e          state_reg;
  icu_state_e          state_next;
  logic [15:0]         vector_reg;
  logic [1:0]          level_reg;
  logic [3:0]          index_reg;
  logic                taken;

  logic [ICU_NEV-1:0]  status_reg;
  logic [ICU_NEV-1:0]  mask_reg;
  logic [ICU_NEV-1:0]  events;

  logic                acc_done_reg;
  logic [31:0]         readdata_reg;
  logic [7:0]          idx;
  logic [2:0]          sel;
  logic                wr_fire;
  logic [7:0]          rd_value;
  logic                rd_mapped;

  // Pins cross into the core clock
  icu_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({external_request_one, external_request_zero}),
    .sync_out (ext_sync)
  );

  // Source requests in polling order
  always_comb begin
    raw_req                  = '0;
    raw_req[ICU_SRC_EXT0]    = ext_sync[0];
    raw_req[ICU_SRC_TIMER0]  = timer0_overflow_flag;
    raw_req[ICU_SRC_EXT1]    = ext_sync[1];
    raw_req[ICU_SRC_TIMER1]  = timer1_overflow_flag;
    raw_req[ICU_SRC_CAPTURE] = capture_counter_flag | (|capture_module_flag);
    raw_req[ICU_SRC_SERIAL]  = uart_rx_flag | uart_tx_flag;
    raw_req[ICU_SRC_TIMER2]  = timer2_overflow_flag;
    raw_req[ICU_SRC_CAN]     = can_tx_ok | can_rx_ok |
      can_error | can_buffer_overrun;
    raw_req[ICU_SRC_ADC]     = converter_done_flag;
    raw_req[ICU_SRC_CANOVF]  = can_timer_overflow_flag;
    raw_req[ICU_SRC_SPI]     = spi_request_flag;
  end

  // Per-source enable and priority bits picked from the registers
  always_comb begin
    src_enable                  = '0;
    src_enable[ICU_SRC_EXT0]    = regs_reg[ICU_REG_EN_MAIN][0];
    src_enable[ICU_SRC_TIMER0]  = regs_reg[ICU_REG_EN_MAIN][1];
    src_enable[ICU_SRC_EXT1]    = regs_reg[ICU_REG_EN_MAIN][2];
    src_enable[ICU_SRC_TIMER1]  = regs_reg[ICU_REG_EN_MAIN][3];
    src_enable[ICU_SRC_SERIAL]  = regs_reg[ICU_REG_EN_MAIN][4];
    src_enable[ICU_SRC_TIMER2]  = regs_reg[ICU_REG_EN_MAIN][5];
    src_enable[ICU_SRC_CAPTURE] = regs_reg[ICU_REG_EN_MAIN][6];
    src_enable[ICU_SRC_CAN]     = regs_reg[ICU_REG_EN_SECOND][0];
    src_enable[ICU_SRC_ADC]     = regs_reg[ICU_REG_EN_SECOND][1];
    src_enable[ICU_SRC_CANOVF]  = regs_reg[ICU_REG_EN_SECOND][2];
    src_enable[ICU_SRC_SPI]     = regs_reg[ICU_REG_EN_SECOND][3];
  end

  // Two-bit level per source
  always_comb begin
    level[ICU_SRC_EXT0]    = {regs_reg[ICU_REG_PH_MAIN][0], regs_reg[ICU_REG_PL_MAIN][0]};
    level[ICU_SRC_TIMER0]  = {regs_reg[ICU_REG_PH_MAIN][1], regs_reg[ICU_REG_PL_MAIN][1]};
    level[ICU_SRC_EXT1]    = {regs_reg[ICU_REG_PH_MAIN][2], regs_reg[ICU_REG_PL_MAIN][2]};
    level[ICU_SRC_TIMER1]  = {regs_reg[ICU_REG_PH_MAIN][3], regs_reg[ICU_REG_PL_MAIN][3]};
    level[ICU_SRC_SERIAL]  = {regs_reg[ICU_REG_PH_MAIN][4], regs_reg[ICU_REG_PL_MAIN][4]};
    level[ICU_SRC_TIMER2]  = {regs_reg[ICU_REG_PH_MAIN][5], regs_reg[ICU_REG_PL_MAIN][5]};
    level[ICU_SRC_CAPTURE] = {regs_reg[ICU_REG_PH_MAIN][6], regs_reg[ICU_REG_PL_MAIN][6]};
    level[ICU_SRC_CAN]     = {regs_reg[ICU_REG_PH_SECOND][0], regs_reg[ICU_REG_PL_SECOND][0]};
    level[ICU_SRC_ADC]     = {regs_reg[ICU_REG_PH_SECOND][1], regs_reg[ICU_REG_PL_SECOND][1]};
    level[ICU_SRC_CANOVF]  = {regs_reg[ICU_REG_PH_SECOND][2], regs_reg[ICU_REG_PL_SECOND][2]};
    level[ICU_SRC_SPI]     = {regs_reg[ICU_REG_PH_SECOND][3], regs_reg[ICU_REG_PL_SECOND][3]};
  end

  // Global enable masks everything
  assign pending = (raw_req & src_enable) &
    {ICU_NSRC{regs_reg[ICU_REG_EN_MAIN][ICU_GLOBAL_EN_BIT]}};

  icu_arbiter u_arbiter (
    .pending (pending),
    .level   (level),
    .pick    (pick)
  );

  // Highest level currently in service
  always_comb begin
    any_active   = |in_service_reg;
    active_level = 2'h0;
    for (int l = 0; l < ICU_NLEVEL; l++) begin
      if (in_service_reg[l]) begin
        active_level = l[1:0];
      end
    end
  end

  // Only a strictly higher level gets through; level 3 therefore never yields
  assign can_preempt = pick.valid &&
    (!any_active || (pick.level > active_level));

  // Core accepts the offer
  assign taken = (state_reg == ICU_ST_OFFER) && core_ack;

  // Offer state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ICU_ST_IDLE: begin
        if (can_preempt) begin
          state_next = ICU_ST_OFFER;
        end
      end
      ICU_ST_OFFER: begin
        if (taken || !can_preempt) begin
          state_next = ICU_ST_IDLE;
        end
      end
      default: begin
        state_next = ICU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= ICU_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Offered vector follows the current winner until the core takes it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vector_reg <= ICU_VECTOR_RESET;
      level_reg  <= 2'h0;
      index_reg  <= 4'h0;
    end else if (can_preempt && !taken) begin
      vector_reg <= ICU_VECTOR[pick.index];
      level_reg  <= pick.level;
      index_reg  <= pick.index;
    end
  end

  assign core_req.valid  = (state_reg == ICU_ST_OFFER);
  assign core_req.level  = level_reg;
  assign core_req.vector = vector_reg;

  // Return retires the highest active level, then an accept marks its own
  always_comb begin
    in_service_next = in_service_reg;
    if (core_return && any_active) begin
      in_service_next[active_level] = 1'b0;
    end
    if (taken) begin
      in_service_next[level_reg] = 1'b1;
    end
  end

  // In-service levels
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_service_reg <= '0;
    end else begin
      in_service_reg <= in_service_next;
    end
  end

  // Sticky events, set wins over write-one-to-clear
  always_comb begin
    events                 = '0;
    events[ICU_EV_TAKEN]   = taken;
    events[ICU_EV_RETURN]  = core_return && any_active;
    events[ICU_EV_PREEMPT] = taken && any_active;
  end

  // Bus decode
  assign idx     = avs_address[9:2];
  assign wr_fire = avs_write && !avs_waitrequest && avs_byteenable[0];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_reg <= ICU_EV_RESET;
    end else if (wr_fire && (idx == ICU_IDX_STATUS)) begin
      status_reg <= (status_reg & ~avs_writedata[ICU_NEV-1:0]) | events;
    end else begin
      status_reg <= status_reg | events;
    end
  end

  // Event mask
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask_reg <= ICU_EV_RESET;
    end else if (wr_fire && (idx == ICU_IDX_MASK)) begin
      mask_reg <= avs_writedata[ICU_NEV-1:0];
    end
  end

  assign irq = |(status_reg & mask_reg);

  // Address index to register slot
  always_comb begin
    case (idx)
      ICU_IDX_EN_MAIN:   sel = ICU_REG_EN_MAIN;
      ICU_IDX_EN_SECOND: sel = ICU_REG_EN_SECOND;
      ICU_IDX_PL_MAIN:   sel = ICU_REG_PL_MAIN;
      ICU_IDX_PH_MAIN:   sel = ICU_REG_PH_MAIN;
      ICU_IDX_PL_SECOND: sel = ICU_REG_PL_SECOND;
      ICU_IDX_PH_SECOND: sel = ICU_REG_PH_SECOND;
      default:           sel = ICU_REG_NONE;
    endcase
  end

  // Whole-byte writes and single-bit set or clear; reserved bits never stored
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int r = 0; r < ICU_NREG; r++) begin
        regs_reg[r] <= ICU_RESET[r];
      end
    end else if (wr_fire) begin
      if (sel != ICU_REG_NONE) begin
        regs_reg[sel] <= avs_writedata[7:0] & ICU_WMASK[sel];
      end else if ((idx == ICU_IDX_BITOP) && (avs_writedata[ICU_BITOP_SEL_LSB +: 3] < 3'(ICU_NREG))) begin
        regs_reg[avs_writedata[ICU_BITOP_SEL_LSB +: 3]][avs_writedata[ICU_BITOP_BIT_LSB +: 3]] <=
          avs_writedata[ICU_BITOP_VAL_BIT] &
          ICU_WMASK[avs_writedata[ICU_BITOP_SEL_LSB +: 3]][avs_writedata[ICU_BITOP_BIT_LSB +: 3]];
      end
    end
  end

  // Read mux; reserved bits read zero
  always_comb begin
    rd_value  = 8'h00;
    rd_mapped = 1'b1;
    if (sel != ICU_REG_NONE) begin
      rd_value = regs_reg[sel];
    end else begin
      case (idx)
        ICU_IDX_STATUS: rd_value = {5'h00, status_reg};
        ICU_IDX_MASK:   rd_value = {5'h00, mask_reg};
        ICU_IDX_STATE:  rd_value = {in_service_reg, index_reg};
        ICU_IDX_BITOP:  rd_value = 8'h00;
        default:        rd_mapped = 1'b0;
      endcase
    end
  end

  // One wait cycle per access
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_done_reg <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      acc_done_reg <= (avs_read || avs_write) && !acc_done_reg;
      if (avs_read && !acc_done_reg) begin
        readdata_reg <= rd_mapped ? {24'h00_0000, rd_value} :
          32'h0000_0000;
      end
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !acc_done_reg;
  assign avs_readdata    = readdata_reg;

endmodule
`default_nettype wire

// File: verif/icu_props.sv
// Port-level assertion checker for the priority interrupt controller
`timescale 1ns/1ns
`default_nettype none
module icu_props
  import icu_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire icu_req_s    core_req,
  input wire logic        core_ack,
  input wire logic        core_return,
  input wire logic        irq
);
  logic [3:0] inserv_reg;
  logic [3:0] inserv_next;
  logic [1:0] top_lvl;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Shadow of the in-service levels: return clears the highest, then ack sets
  always_comb begin
    inserv_next = inserv_reg;
    for (int i = 0; i < 4; i++) begin
      if (core_return && inserv_reg[i] && (inserv_reg >> (i + 1)) == 4'h0) inserv_next[i] = 1'b0;
    end
    if (core_ack && core_req.valid) inserv_next[core_req.level] = 1'b1;
  end

  always_comb begin
    top_lvl = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (inserv_reg[i]) top_lvl = 2'(i);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) inserv_reg <= 4'h0;
    else inserv_reg <= inserv_next;
  end

  a_wait_one_cycle: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("bus wait not one cycle");
  a_idle_no_wait: assert property (
    !(avs_read || avs_write) |-> !avs_waitrequest) else $error("waitrequest while idle");
  a_rdata_upper_zero: assert property (
    avs_readdata[31:8] == 24'h0) else $error("read data upper bits set");
  a_ack_drops_valid: assert property (
    core_ack && core_req.valid |=> !core_req.valid) else $error("offer held after ack");
  a_vector_known: assert property (
    core_req.valid |-> core_req.vector inside {16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
      16'h0033, 16'h003b, 16'h0043, 16'h004b, 16'h0053}) else $error("unknown vector offered");
  a_no_equal_preempt: assert property (
    core_req.valid && inserv_reg != 4'h0 |-> core_req.level > top_lvl) else $error("offer not above active level");
  a_top_level_blocks: assert property (
    inserv_reg[3] |-> !core_req.valid) else $error("offer during top level handler");
  a_irq_has_cause: assert property (
    $rose(irq) |-> $past(core_ack) || $past(core_return) || $past(avs_write)) else $error("irq rose without event");
endmodule

bind icu_controller icu_props u_icu_props (
  .clk_sys(clk_sys), .rst(rst), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .core_req(core_req), .core_ack(core_ack), .core_return(core_return),
  .irq(irq));
`default_nettype wire

// File: verif/icu_core_model.sv
// Behavioural CPU core: accepts vector offers and signals handler returns
`timescale 1ns/1ns
`default_nettype none
module icu_core_model
  import icu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire icu_req_s    core_req,
  input  wire logic        ack_hold,
  input  wire logic [3:0]  ack_delay,
  input  wire logic        return_cmd,
  output logic             core_ack,
  output logic             core_return,
  output logic      [15:0] taken_vector,
  output logic      [1:0]  taken_level,
  output logic      [7:0]  taken_count
);
  logic [3:0] wait_reg;

  // Acknowledge an offer after the programmed delay, as a one-cycle pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      core_ack <= 1'b0;
      wait_reg <= 4'h0;
    end else if (core_req.valid && !core_ack && !ack_hold) begin
      core_ack <= (wait_reg >= ack_delay);
      wait_reg <= (wait_reg >= ack_delay) ? 4'h0 : wait_reg + 4'h1;
    end else begin
      core_ack <= 1'b0;
      wait_reg <= 4'h0;
    end
  end

  // Record what the controller handed over at the accepting edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      taken_vector <= 16'h0;
      taken_level <= 2'h0;
      taken_count <= 8'h0;
      core_return <= 1'b0;
    end else begin
      core_return <= return_cmd;
      if (core_ack && core_req.valid) begin
        taken_vector <= core_req.vector;
        taken_level <= core_req.level;
        taken_count <= taken_count + 8'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/icu_controller_test.sv
// Self-checking testbench for the priority interrupt controller
`timescale 1ns/1ns
`default_nettype none
`define ICU_CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); end end
module icu_controller_test
  import icu_pkg::*;
;
  localparam logic [15:0] VEC [11] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0033, 16'h0023,
    16'h002b, 16'h003b, 16'h0043, 16'h004b, 16'h0053};
  logic        clk_sys;
  logic        rst;
  logic [9:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [19:0] flags;
  icu_req_s    core_req;
  logic        core_ack;
  logic        core_return;
  logic        irq;
  logic        ack_hold;
  logic [3:0]  ack_delay;
  logic        return_cmd;
  logic [15:0] taken_vector;
  logic [1:0]  taken_level;
  logic [7:0]  taken_count;
  int          fail_count = 0;
  int          samples_checked = 0;

  icu_controller u_icu_controller (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .external_request_zero(flags[0]), .external_request_one(flags[2]),
    .timer0_overflow_flag(flags[1]), .timer1_overflow_flag(flags[3]), .timer2_overflow_flag(flags[6]),
    .capture_counter_flag(flags[4]), .capture_module_flag(flags[15:11]), .uart_rx_flag(flags[5]),
    .uart_tx_flag(flags[16]), .can_tx_ok(flags[7]), .can_rx_ok(flags[17]), .can_error(flags[18]),
    .can_buffer_overrun(flags[19]), .converter_done_flag(flags[8]), .can_timer_overflow_flag(flags[9]),
    .spi_request_flag(flags[10]), .core_req(core_req), .core_ack(core_ack), .core_return(core_return),
    .irq(irq));

  icu_core_model u_icu_core_model (
    .clk_sys(clk_sys), .rst(rst), .core_req(core_req), .ack_hold(ack_hold), .ack_delay(ack_delay),
    .return_cmd(return_cmd), .core_ack(core_ack), .core_return(core_return), .taken_vector(taken_vector),
    .taken_level(taken_level), .taken_count(taken_count));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Flag bits owned by each source, so a served source can be cleared whole
  function automatic logic [19:0] smask(input int s);
    smask = 20'h1 << s;
    if (s == 4) smask |= 20'h0f800;
    if (s == 5) smask |= 20'h10000;
    if (s == 7) smask |= 20'he0000;
  endfunction

  task automatic bus(input bit wrt, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
    avs_address <= {idx, 2'b00};
    avs_writedata <= d;
    avs_write <= wrt;
    avs_read <= !wrt;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, q);
    `ICU_CHK(q, e)
  endtask

  task automatic do_ret();
    return_cmd <= 1'b1;
    @(posedge clk_sys);
    return_cmd <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic serve(input int s, input logic [1:0] lvl, input bit ret);
    logic [7:0] n0;
    int         k;
    n0 = taken_count;
    k = 0;
    while (taken_count === n0 && k < 300) begin
      @(posedge clk_sys);
      k++;
    end
    `ICU_CHK(k < 300, 1'b1)
    `ICU_CHK(taken_vector, VEC[s])
    `ICU_CHK(taken_level, lvl)
    flags <= flags & ~smask(s);
    @(posedge clk_sys);
    if (ret) do_ret();
  endtask

  task automatic quiet(input int n);
    logic [7:0] n0;
    n0 = taken_count;
    repeat (n) @(posedge clk_sys);
    `ICU_CHK(taken_count, n0)
  endtask

  task automatic t_regs();
    logic [7:0] idx [6] = '{8'ha8, 8'he8, 8'hb8, 8'hb7, 8'hf8, 8'hf7};
    logic [7:0] msk [6] = '{8'hff, 8'h0f, 8'h7f, 8'h7f, 8'h0f, 8'h0f};
    for (int i = 0; i < 6; i++) begin
      rd(idx[i], 32'h0);
      wr(idx[i], {24'h0, msk[i]});
      rd(idx[i], {24'h0, msk[i]});
      wr(idx[i], 32'h0);
    end
    avs_byteenable <= 4'h0;
    wr(8'ha8, 32'hff);
    avs_byteenable <= 4'h1;
    rd(8'ha8, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h41, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_polling();
    wr(8'ha8, 32'hff);
    wr(8'he8, 32'h0f);
    ack_hold <= 1'b1;
    flags <= 20'h007ff;
    repeat (6) @(posedge clk_sys);
    ack_hold <= 1'b0;
    for (int s = 0; s < 11; s++) serve(s, 2'h0, 1'b1);
    for (int k = 11; k < 20; k++) begin
      flags <= 20'h1 << k;
      serve(k < 16 ? 4 : (k == 16 ? 5 : 7), 2'h0, 1'b1);
    end
    $display("t_polling done");
  endtask

  task automatic t_priority();
    wr(8'hf7, 32'h08);
    wr(8'hf8, 32'h0a);
    wr(8'hb7, 32'h08);
    ack_hold <= 1'b1;
    ack_delay <= 4'h3;
    flags <= 20'h00509;
    repeat (6) @(posedge clk_sys);
    ack_hold <= 1'b0;
    serve(10, 2'h3, 1'b0);
    quiet(20);
    do_ret();
    serve(3, 2'h2, 1'b1);
    serve(8, 2'h1, 1'b1);
    serve(0, 2'h0, 1'b1);
    ack_delay <= 4'h0;
    wr(8'hf7, 32'h0);
    wr(8'hf8, 32'h0);
    wr(8'hb7, 32'h0);
    $display("t_priority done");
  endtask

  task automatic t_preempt();
    wr(8'h41, 32'h07);
    wr(8'h42, 32'h04);
    wr(8'hb8, 32'h20);
    flags <= 20'h1;
    serve(0, 2'h0, 1'b0);
    flags <= 20'h2;
    quiet(20);
    `ICU_CHK(irq, 1'b0)
    flags <= 20'h42;
    serve(6, 2'h1, 1'b0);
    `ICU_CHK(irq, 1'b1)
    rd(8'h41, 32'h05);
    wr(8'h41, 32'h04);
    `ICU_CHK(irq, 1'b0)
    do_ret();
    quiet(20);
    do_ret();
    serve(1, 2'h0, 1'b1);
    rd(8'h41, 32'h03);
    wr(8'h41, 32'h07);
    wr(8'h42, 32'h0);
    wr(8'hb8, 32'h0);
    $display("t_preempt done");
  endtask

  task automatic t_enables();
    wr(8'h40, 32'h00a);
    flags <= 20'h200;
    quiet(20);
    wr(8'h40, 32'h10a);
    serve(9, 2'h0, 1'b1);
    wr(8'h40, 32'h007);
    flags <= 20'h4;
    quiet(20);
    rd(8'ha8, 32'h7f);
    wr(8'ha8, 32'h80);
    quiet(20);
    wr(8'ha8, 32'h84);
    serve(2, 2'h0, 1'b1);
    rd(8'h43, 32'h02);
    $display("t_enables done");
  endtask

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    rst = 1'b1;
    flags = 20'h0;
    avs_address = 10'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    ack_hold = 1'b0;
    ack_delay = 4'h0;
    return_cmd = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_polling();
    t_priority();
    t_preempt();
    t_enables();
    finish_test();
  end
endmodule
`default_nettype wire
